// ===== logic/seq_pkg.sv
package seq_pkg;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STAT   = 4'h4;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam logic [4:0]  MUL_MAX     = 5'h10;
  localparam logic [31:0] OFS_PC8     = 32'h8;
  localparam logic [31:0] OFS_PC12    = 32'hC;
  localparam logic [31:0] OFS_WORD    = 32'h4;

  typedef enum logic [2:0] {
    CL_MUL = 3'h0, CL_LDR = 3'h1, CL_STR = 3'h2, CL_LDM = 3'h3,
    CL_STM = 3'h4, CL_SWP = 3'h5, CL_EXC = 3'h6, CL_CDP = 3'h7
  } cls_e;

  typedef enum logic [1:0] {
    OP_IN = 2'h0, OP_RD = 2'h1, OP_WR = 2'h2, OP_TR = 2'h3
  } op_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_C1 = 4'h1, S_MUL = 4'h2, S_LDR2 = 4'h3,
    S_LDR3 = 4'h4, S_STR2 = 4'h5, S_LDM = 4'h6, S_LDMF = 4'h7,
    S_STM = 4'h8, S_SWR = 4'h9, S_SWW = 4'hA, S_SWF = 4'hB,
    S_RFN = 4'hC, S_RFS = 4'hD, S_CP2 = 4'hE
  } state_e;

  typedef struct packed {
    cls_e        cls;
    logic [31:0] mul_rs;
    logic        byte_sz;
    logic        xlat;
    logic        wb;
    logic        base_pc;
    logic        dest_pc;
    logic        accum;
    logic [4:0]  nregs;
    logic        pc_in_list;
    logic        flags_set;
    logic        irq_dis;
    logic [1:0]  mode;
  } cmd_s;

  typedef struct packed {
    op_e         op;
    logic        seq;
    logic [31:0] addr;
    logic        byte_sz;
    logic        user;
    logic        lock;
    logic        bypass;
    logic        supervisor_mode;
    logic        opcode_fetch_n;
    logic        coproc_instr_n;
  } bus_s;

  typedef struct packed {
    logic rd_we;
    logic base_we;
    logic base_restore;
    logic r14_we;
    logic r14_adj;
    logic pc_flush;
    logic acc_init;
    logic acc_keep;
    logic booth;
  } wr_s;

  typedef struct packed {
    state_e      state;
    cmd_s        cmd;
    logic [4:0]  cnt;
    logic [31:0] tgt;
    logic        abt;
    logic        first;
    logic        refill;
    logic        nseq;
    logic        en;
    logic [2:0]  cpa_s;
    logic [2:0]  cpb_s;
    logic        cpa_v;
    logic        cpb_v;
    bus_s        bus;
    wr_s         wr;
    logic        done;
    logic        undef;
    logic        aexc;
    logic [31:0] rdata;
  } st_s;
endpackage

// ===== logic/instruction_cycle_sequencer.sv
// What this block does
// - Multiply runs m Booth cycles from the multiplier; zero or one gives one, max 16.
// - Multiply cycles after the first are internal; first cycle sets accumulate or zero.
// - Load cycle one computes address with prefetch; cycle two reads N with base update.
// - Load cycle three writes destination during internal cycle; next fetch N at PC+12.
// - Single transfers are byte or word; translate bit forces user mode in data cycle.
// - Aborted load data fetch blocks base update and destination write.
// - Load writing PC refills: N fetch at new address, then S at +4.
// - Store writes data in cycle two with base update; no third cycle.
// - Store changes PC only as written-back base, then refills from that address.
// - Aborted store write blocks base write-back.
// - Store multiple writes N then S per register; no final internal cycle.
// - Load multiple: address, first read with base update, S reads, final internal write.
// - Load multiple abort completes sequence, blocks later writes, restores base at end.
// - Load multiple with PC as base suppresses write-back.
// - PC loaded last in load multiple; loaded without abort means pipeline refill.
// - Swap reads external memory in cycle two, writes in three, updates dest in four.
// - Lock stays high over swap read and write; memory lets both complete.
// - Swap with PC base traps if flags set or irq off, else swaps at PC+8 with mode in the low two bits.
// - Aborted swap read or write leaves destination unchanged.
// - Exception entry: supervisor and link in cycle one, vector fetch with link adjust in two, then refill.
// - Able but unready coprocessor holds absent low, busy high; core busy-waits.
// - Every coprocessor instruction busy-waits cycle two while the coprocessor catches up.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module instruction_cycle_sequencer (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // Instruction issue
  input  wire logic          start,
  input  seq_pkg::cmd_s      cmd,
  input  wire logic [31:0]   pc,
  input  wire logic [31:0]   alu_addr,
  input  wire logic [31:0]   wb_addr,
  input  wire logic [31:0]   vec_addr,
  // Memory response
  input  wire logic          data_abort,
  input  wire logic [31:0]   load_data,
  // Coprocessor pins
  input  wire logic          coproc_absent_line,
  input  wire logic          coproc_busy_line,
  // Register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  // Cycle outputs
  output seq_pkg::bus_s      bus,
  output seq_pkg::wr_s       wr,
  output logic               idle,
  output logic               done,
  output logic               undef_trap,
  output logic               addr_exc
);
  seq_pkg::st_s st_q;
  seq_pkg::st_s st_d;

  function automatic logic [4:0] booth_cycles(input logic [31:0] v);
    logic [4:0] m;
    m = 5'h1;
    for (int i = 1; i < 32; i++) begin
      if (v[i]) m = 5'((i + 3) / 2);
    end
    if (m > seq_pkg::MUL_MAX) m = seq_pkg::MUL_MAX;
    return m;
  endfunction

  function automatic seq_pkg::bus_s mk_bus(input seq_pkg::op_e op, input logic sq,
                                           input logic [31:0] a, input logic ofn);
    seq_pkg::bus_s b;
    b = '0;
    b.op = op;
    b.seq = sq;
    b.addr = a;
    b.opcode_fetch_n = ofn;
    b.coproc_instr_n = 1'b1;
    return b;
  endfunction

  always_comb begin
    logic        fin;
    logic        fin_seq;
    logic        ab;
    logic [31:0] swa;
    st_d = st_q;
    fin = 1'b0;
    fin_seq = 1'b0;
    ab = st_q.abt | data_abort;
    swa = st_q.cmd.base_pc ? {st_q.tgt[31:2], st_q.cmd.mode} : alu_addr;
    st_d.wr = '0;
    st_d.done = 1'b0;
    st_d.undef = 1'b0;
    st_d.aexc = 1'b0;
    st_d.rdata = '0;
    // Only the agreeing later stages feed the filtered level
    st_d.cpa_s = {st_q.cpa_s[1:0], coproc_absent_line};
    st_d.cpb_s = {st_q.cpb_s[1:0], coproc_busy_line};
    if (st_q.cpa_s[1] == st_q.cpa_s[2]) st_d.cpa_v = st_q.cpa_s[2];
    if (st_q.cpb_s[1] == st_q.cpb_s[2]) st_d.cpb_v = st_q.cpb_s[2];
    if (reg_wr && reg_addr == seq_pkg::ADDR_CTRL) st_d.en = reg_wdata[seq_pkg::CTRL_EN_BIT];
    if (reg_rd) begin
      case (reg_addr)
        seq_pkg::ADDR_CTRL: st_d.rdata = {31'h0, st_q.en};
        seq_pkg::ADDR_STAT: st_d.rdata = {16'h0, st_q.cpb_v, st_q.cpa_v, st_q.refill,
                                          st_q.abt, st_q.cnt, 3'(st_q.cmd.cls), st_q.state};
        default:            st_d.rdata = '0;
      endcase
    end
    case (st_q.state)
      seq_pkg::S_IDLE: begin
        if (start && st_q.en) begin
          st_d.state = seq_pkg::S_C1;
          st_d.cmd = cmd;
          st_d.abt = 1'b0;
          st_d.refill = 1'b0;
          st_d.first = 1'b1;
          st_d.tgt = pc + seq_pkg::OFS_PC8;
          st_d.bus = mk_bus(seq_pkg::OP_RD, st_q.nseq, pc + seq_pkg::OFS_PC8, 1'b1);
          st_d.cnt = booth_cycles(cmd.mul_rs);
          st_d.wr.acc_init = (cmd.cls == seq_pkg::CL_MUL);
          st_d.wr.acc_keep = (cmd.cls == seq_pkg::CL_MUL) && cmd.accum;
          if (cmd.cls == seq_pkg::CL_EXC) begin
            st_d.bus.supervisor_mode = 1'b1;
            st_d.wr.r14_we = 1'b1;
          end
        end
      end
      seq_pkg::S_C1: begin
        case (st_q.cmd.cls)
          seq_pkg::CL_MUL: begin
            st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0, pc + seq_pkg::OFS_PC12, 1'b0);
            st_d.wr.booth = 1'b1;
            st_d.cnt = st_q.cnt - 5'h1;
            st_d.state = seq_pkg::S_MUL;
          end
          seq_pkg::CL_LDR, seq_pkg::CL_STR: begin
            st_d.bus = mk_bus(st_q.cmd.cls == seq_pkg::CL_LDR ? seq_pkg::OP_RD : seq_pkg::OP_WR,
                              1'b0, alu_addr, 1'b0);
            st_d.bus.byte_sz = st_q.cmd.byte_sz;
            st_d.bus.user = st_q.cmd.xlat;
            st_d.state = st_q.cmd.cls == seq_pkg::CL_LDR ? seq_pkg::S_LDR2 : seq_pkg::S_STR2;
          end
          seq_pkg::CL_LDM, seq_pkg::CL_STM: begin
            st_d.bus = mk_bus(st_q.cmd.cls == seq_pkg::CL_LDM ? seq_pkg::OP_RD : seq_pkg::OP_WR,
                              1'b0, alu_addr, 1'b0);
            st_d.wr.base_we = (st_q.cmd.cls == seq_pkg::CL_STM) && st_q.cmd.wb;
            st_d.cnt = st_q.cmd.nregs - 5'h1;
            st_d.state = st_q.cmd.cls == seq_pkg::CL_LDM ? seq_pkg::S_LDM : seq_pkg::S_STM;
          end
          seq_pkg::CL_SWP: begin
            if (st_q.cmd.base_pc && (st_q.cmd.flags_set || st_q.cmd.irq_dis)) begin
              st_d.aexc = 1'b1;
              st_d.tgt = vec_addr;
              st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b0, vec_addr, 1'b0);
              st_d.bus.supervisor_mode = 1'b1;
              st_d.wr.r14_we = 1'b1;
              st_d.state = seq_pkg::S_RFN;
            end else begin
              st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b0, swa, 1'b0);
              st_d.bus.byte_sz = st_q.cmd.byte_sz;
              st_d.bus.lock = 1'b1;
              st_d.bus.bypass = 1'b1;
              st_d.tgt = swa;
              st_d.state = seq_pkg::S_SWR;
            end
          end
          seq_pkg::CL_EXC: begin
            st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b0, vec_addr, 1'b0);
            st_d.bus.supervisor_mode = 1'b1;
            st_d.wr.r14_adj = 1'b1;
            st_d.tgt = vec_addr;
            st_d.state = seq_pkg::S_RFN;
          end
          default: begin
            // Cycle two of a coprocessor instruction always waits
            st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0, pc + seq_pkg::OFS_PC8, 1'b0);
            st_d.bus.coproc_instr_n = 1'b0;
            st_d.state = seq_pkg::S_CP2;
          end
        endcase
      end
      seq_pkg::S_MUL: begin
        if (st_q.cnt == 5'h0) begin
          fin = 1'b1;
        end else begin
          st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0, pc + seq_pkg::OFS_PC12, 1'b1);
          st_d.wr.booth = 1'b1;
          st_d.cnt = st_q.cnt - 5'h1;
        end
      end
      seq_pkg::S_LDR2: begin
        st_d.abt = data_abort;
        st_d.tgt = st_q.cmd.dest_pc ? load_data : wb_addr;
        st_d.refill = !data_abort && (st_q.cmd.dest_pc || (st_q.cmd.base_pc && st_q.cmd.wb));
        st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0,
                          (st_q.cmd.base_pc && st_q.cmd.wb) ? wb_addr : pc + seq_pkg::OFS_PC12,
                          1'b1);
        st_d.wr.rd_we = !data_abort && !st_q.cmd.dest_pc;
        st_d.wr.base_we = !data_abort && st_q.cmd.wb && !st_q.cmd.base_pc;
        st_d.state = seq_pkg::S_LDR3;
      end
      seq_pkg::S_LDR3, seq_pkg::S_LDMF, seq_pkg::S_SWF: begin
        if (st_q.refill) begin
          st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b0, st_q.tgt, 1'b1);
          st_d.wr.pc_flush = 1'b1;
          st_d.state = seq_pkg::S_RFN;
        end else begin
          fin = 1'b1;
        end
      end
      seq_pkg::S_STR2: begin
        st_d.wr.base_we = !data_abort && st_q.cmd.wb;
        if (!data_abort && st_q.cmd.base_pc && st_q.cmd.wb) begin
          st_d.tgt = wb_addr;
          st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b0, wb_addr, 1'b1);
          st_d.wr.pc_flush = 1'b1;
          st_d.state = seq_pkg::S_RFN;
        end else begin
          fin = 1'b1;
        end
      end
      seq_pkg::S_STM: begin
        if (st_q.cnt == 5'h0) begin
          fin = 1'b1;
        end else begin
          st_d.bus = mk_bus(seq_pkg::OP_WR, 1'b1, st_q.bus.addr + seq_pkg::OFS_WORD, 1'b1);
          st_d.cnt = st_q.cnt - 5'h1;
        end
      end
      seq_pkg::S_LDM: begin
        st_d.abt = ab;
        st_d.first = 1'b0;
        st_d.wr.base_we = st_q.first && !ab && st_q.cmd.wb && !st_q.cmd.base_pc;
        st_d.wr.rd_we = !ab && !(st_q.cnt == 5'h0 && st_q.cmd.pc_in_list);
        if (st_q.cnt == 5'h0) begin
          st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0, pc + seq_pkg::OFS_PC12, 1'b1);
          st_d.wr.base_restore = ab && st_q.cmd.wb && !st_q.cmd.base_pc;
          st_d.refill = !ab && st_q.cmd.pc_in_list;
          st_d.tgt = load_data;
          st_d.state = seq_pkg::S_LDMF;
        end else begin
          st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b1, st_q.bus.addr + seq_pkg::OFS_WORD, 1'b1);
          st_d.cnt = st_q.cnt - 5'h1;
        end
      end
      seq_pkg::S_SWR: begin
        st_d.abt = data_abort;
        st_d.tgt = load_data;
        st_d.bus = mk_bus(seq_pkg::OP_WR, 1'b0, st_q.bus.addr, 1'b1);
        st_d.bus.byte_sz = st_q.cmd.byte_sz;
        st_d.bus.lock = 1'b1;
        st_d.bus.bypass = 1'b1;
        st_d.state = seq_pkg::S_SWW;
      end
      seq_pkg::S_SWW: begin
        st_d.abt = ab;
        st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0, pc + seq_pkg::OFS_PC12, 1'b1);
        st_d.wr.rd_we = !ab && !st_q.cmd.dest_pc;
        st_d.refill = !ab && st_q.cmd.dest_pc;
        st_d.state = seq_pkg::S_SWF;
      end
      seq_pkg::S_RFN: begin
        st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b1, st_q.tgt + seq_pkg::OFS_WORD, 1'b0);
        st_d.bus.supervisor_mode = st_q.bus.supervisor_mode;
        st_d.wr.r14_adj = st_q.bus.supervisor_mode && st_q.cmd.cls != seq_pkg::CL_EXC;
        st_d.state = seq_pkg::S_RFS;
      end
      seq_pkg::S_RFS: begin
        fin = 1'b1;
        fin_seq = 1'b1;
      end
      seq_pkg::S_CP2: begin
        if (st_q.cpa_v && st_q.cpb_v) begin
          // Nobody claimed it: take the undefined trap
          st_d.undef = 1'b1;
          st_d.tgt = vec_addr;
          st_d.bus = mk_bus(seq_pkg::OP_RD, 1'b0, vec_addr, 1'b0);
          st_d.bus.supervisor_mode = 1'b1;
          st_d.wr.r14_we = 1'b1;
          st_d.state = seq_pkg::S_RFN;
        end else if (!st_q.cpb_v) begin
          fin = 1'b1;
        end else begin
          st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0, pc + seq_pkg::OFS_PC8, 1'b1);
          st_d.bus.coproc_instr_n = 1'b0;
        end
      end
      default: begin
        st_d.state = seq_pkg::S_IDLE;
      end
    endcase
    if (fin) begin
      st_d.state = seq_pkg::S_IDLE;
      st_d.bus = mk_bus(seq_pkg::OP_IN, 1'b0, 32'h0, 1'b1);
      st_d.done = 1'b1;
      st_d.nseq = fin_seq;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.en <= seq_pkg::CTRL_EN_RST;
      st_q.bus.opcode_fetch_n <= 1'b1;
      st_q.bus.coproc_instr_n <= 1'b1;
      // Stages start at the idle pin level so no false change follows reset
      st_q.cpa_s <= 3'h7;
      st_q.cpb_s <= 3'h7;
      st_q.cpa_v <= 1'b1;
      st_q.cpb_v <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata  = st_q.rdata;
  assign bus        = st_q.bus;
  assign wr         = st_q.wr;
  assign idle       = (st_q.state == seq_pkg::S_IDLE);
  assign done       = st_q.done;
  assign undef_trap = st_q.undef;
  assign addr_exc   = st_q.aexc;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence swap_read;
    st_q.state == seq_pkg::S_SWR && st_q.bus.op == seq_pkg::OP_RD;
  endsequence
  sequence swap_write;
    st_q.bus.op == seq_pkg::OP_WR && st_q.bus.lock;
  endsequence

  a_swap_lock_pair: assert property (swap_read |-> st_q.bus.lock ##1 swap_write)
    else $error("swap cycles not locked");
  a_lock_only_swap: assert property (st_q.bus.lock |->
    (st_q.state == seq_pkg::S_SWR || st_q.state == seq_pkg::S_SWW))
    else $error("lock outside swap");
  a_swap_abort_dest: assert property ((st_q.state == seq_pkg::S_SWW && data_abort)
    |=> !st_q.wr.rd_we)
    else $error("aborted swap wrote destination");
  a_mul_internal: assert property (st_q.state == seq_pkg::S_MUL |->
    st_q.bus.op == seq_pkg::OP_IN && st_q.cnt < seq_pkg::MUL_MAX)
    else $error("multiply cycle not internal");
  a_ldr_three_cycle: assert property (st_q.state == seq_pkg::S_LDR2 |->
    st_q.bus.op == seq_pkg::OP_RD && !st_q.bus.seq ##1 st_q.bus.op == seq_pkg::OP_IN)
    else $error("load cycle order wrong");
  a_ldr_abort_block: assert property ((st_q.state == seq_pkg::S_LDR2 && data_abort)
    |=> !st_q.wr.rd_we && !st_q.wr.base_we ##1 !st_q.wr.pc_flush)
    else $error("aborted load wrote registers");
  a_str_abort_wb: assert property ((st_q.state == seq_pkg::S_STR2 && data_abort)
    |=> !st_q.wr.base_we && st_q.state == seq_pkg::S_IDLE)
    else $error("aborted store wrote base");
  a_stm_sequential: assert property (st_q.state == seq_pkg::S_STM && st_q.cnt != 5'h0
    |=> st_q.bus.op == seq_pkg::OP_WR && st_q.bus.seq)
    else $error("store multiple not sequential");
  // The wait cycle itself never finishes; the coprocessor answer only counts afterwards
  a_cp_wait_cycle: assert property (st_q.state == seq_pkg::S_C1 &&
    st_q.cmd.cls == seq_pkg::CL_CDP |=> st_q.state == seq_pkg::S_CP2 &&
    st_q.bus.op == seq_pkg::OP_IN && !st_q.bus.coproc_instr_n && !st_q.done)
    else $error("coprocessor wait cycle missing");
  a_refill_pair: assert property (st_q.state == seq_pkg::S_RFN |->
    !st_q.bus.seq ##1 st_q.bus.seq ##1 st_q.done)
    else $error("refill sequence wrong");
endmodule

// ===== verif/mem_cop_model.sv
`timescale 1ns/10ps
module mem_cop_model (
  // Clock
  input  wire logic         mclk,
  // Memory side
  input  seq_pkg::bus_s     bus,
  input  seq_pkg::op_e      abt_op,
  input  wire logic [31:0]  abt_addr,
  output logic              data_abort,
  output logic [31:0]       load_data,
  // Coprocessor side
  input  wire logic         cp_sel,
  input  wire logic         cp_can,
  input  wire logic [3:0]   cp_wait,
  output logic              coproc_absent_line,
  output logic              coproc_busy_line
);
  logic [3:0] cnt_q;

  // Word tracks its address; off a read the lines show the inverse, never a stale value
  assign load_data = (bus.op == seq_pkg::OP_RD) ? bus.addr + 32'h100 : ~(bus.addr + 32'h100);
  // Zero-wait memory: a locked pair runs through unless the bench commands an abort
  assign data_abort = (abt_op != seq_pkg::OP_IN) && (bus.op == abt_op) && (bus.addr == abt_addr);

  always_ff @(posedge mclk) begin
    if (!cp_sel) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Lines float to the pull-up level unless this unit claims the instruction
  assign coproc_absent_line = !(cp_sel && cp_can);
  // Busy drops only once the unit has committed to the operation
  assign coproc_busy_line = !(cp_sel && cp_can && cnt_q >= cp_wait);
endmodule

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    seq_pkg::bus_s b;
    seq_pkg::wr_s  w;
  } rec_s;
  localparam logic [31:0] PCV = 32'h1000;
  localparam logic [31:0] AL  = 32'h2000;
  localparam logic [31:0] WB  = 32'h3000;
  localparam logic [31:0] VEC = 32'h1C;
  logic          mclk, sys_rst, start, data_abort, cp_sel, cp_can, reg_wr, reg_rd;
  logic          coproc_absent_line, coproc_busy_line, idle, done, undef_trap, addr_exc;
  logic [31:0]   pc, alu_addr, wb_addr, vec_addr, load_data, reg_wdata, reg_rdata, abt_addr;
  logic [3:0]    reg_addr, cp_wait;
  seq_pkg::cmd_s cmd;
  seq_pkg::bus_s bus;
  seq_pkg::wr_s  wr;
  seq_pkg::op_e  abt_op;
  rec_s          r[$];
  int            mismatches, tests_run, n_ae, n_ud, n_cpi;
  logic [31:0]   rs_t[4] = '{32'h0, 32'h1, 32'h8, 32'hFFFFFFFF};
  int            m_t[4] = '{1, 1, 3, 16};

  instruction_cycle_sequencer uut (
    .mclk, .sys_rst, .start, .cmd, .pc, .alu_addr, .wb_addr, .vec_addr, .data_abort,
    .load_data, .coproc_absent_line, .coproc_busy_line, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .bus, .wr, .idle, .done, .undef_trap, .addr_exc
  );
  mem_cop_model partner (
    .mclk, .bus, .abt_op, .abt_addr, .data_abort, .load_data, .cp_sel, .cp_can, .cp_wait,
    .coproc_absent_line, .coproc_busy_line
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic abt(input seq_pkg::op_e o, input logic [31:0] a);
    @(posedge mclk);
    abt_op <= o;
    abt_addr <= a;
  endtask

  // Lines need five cycles to clear the three-flop synchroniser before the start
  task automatic cp(input logic can, input logic [3:0] w);
    @(posedge mclk);
    cp_sel <= 1'b0;
    @(posedge mclk);
    cp_sel <= 1'b1;
    cp_can <= can;
    cp_wait <= w;
    repeat (5) @(posedge mclk);
  endtask

  // Records every cycle from cycle one through the done cycle
  task automatic run(input seq_pkg::cmd_s c);
    bit ok;
    r.delete();
    n_ae = 0;
    n_ud = 0;
    n_cpi = 0;
    @(posedge mclk);
    start <= 1'b1;
    cmd <= c;
    @(posedge mclk);
    start <= 1'b0;
    for (int k = 0; k < 64 && !ok; k++) begin
      #1;
      r.push_back({bus, wr});
      n_ae += int'(addr_exc === 1'b1);
      n_ud += int'(undef_trap === 1'b1);
      n_cpi += int'(bus.coproc_instr_n === 1'b0);
      ok = (done === 1'b1);
      if (!ok) @(posedge mclk);
    end
    if (!ok) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic bc(input int i, input seq_pkg::op_e o, input logic s, input logic [31:0] a);
    chk(r[i].b.op, o);
    if (s !== 1'bx) chk(r[i].b.seq, s);
    chk(r[i].b.addr, a);
  endtask

  function automatic int hits(input logic [31:0] a);
    int h;
    foreach (r[k]) begin
      if (r[k].b.op == seq_pkg::OP_RD && r[k].b.seq == 1'b0 && r[k].b.addr == a) h++;
    end
    return h;
  endfunction

  initial begin
    seq_pkg::cmd_s c;
    logic [31:0]   v;
    sys_rst = 1'b1;
    start = 1'b0;
    cmd = '0;
    pc = PCV;
    alu_addr = AL;
    wb_addr = WB;
    vec_addr = VEC;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    abt_op = seq_pkg::OP_IN;
    abt_addr = 32'h0;
    cp_sel = 1'b0;
    cp_can = 1'b0;
    cp_wait = 4'h0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(4'h0, v);
    chk(v[0], 1'b1);
    rd(4'h8, v);
    chk(v, 32'h0);
    rd(4'h4, v);
    chk(v[3:0], seq_pkg::S_IDLE);
    // A start with the enable cleared must leave the sequencer parked
    c = '0;
    c.cls = seq_pkg::CL_MUL;
    wrr(4'h0, 32'h0);
    @(posedge mclk);
    start <= 1'b1;
    cmd <= c;
    @(posedge mclk);
    start <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({idle, bus.op}, {1'b1, seq_pkg::OP_IN});
    wrr(4'h0, 32'h1);
    for (int i = 0; i < 4; i++) begin
      c.mul_rs = rs_t[i];
      c.accum = i[0];
      run(c);
      chk(r.size(), m_t[i] + 2);
      chk({r[0].w.acc_init, r[0].w.acc_keep}, {1'b1, i[0]});
      for (int k = 1; k <= m_t[i]; k++) begin
        chk({r[k].b.op, r[k].w.booth}, {seq_pkg::OP_IN, 1'b1});
      end
    end
    c = '0;
    c.cls = seq_pkg::CL_LDR;
    c.byte_sz = 1'b1;
    c.xlat = 1'b1;
    c.wb = 1'b1;
    run(c);
    chk(r.size(), 4);
    bc(1, seq_pkg::OP_RD, 1'b0, AL);
    chk({r[1].b.byte_sz, r[1].b.user}, 2'b11);
    bc(2, seq_pkg::OP_IN, 1'bx, PCV + 32'hC);
    chk({r[2].w.rd_we, r[2].w.base_we}, 2'b11);
    abt(seq_pkg::OP_RD, AL);
    run(c);
    chk(r[0].b.seq, 1'b0);
    chk({r[2].w.rd_we, r[2].w.base_we}, 2'b00);
    abt(seq_pkg::OP_IN, 32'h0);
    c.dest_pc = 1'b1;
    run(c);
    chk(r.size(), 6);
    bc(3, seq_pkg::OP_RD, 1'b0, AL + 32'h100);
    chk(r[3].w.pc_flush, 1'b1);
    bc(4, seq_pkg::OP_RD, 1'b1, AL + 32'h104);
    c = '0;
    c.cls = seq_pkg::CL_STR;
    c.wb = 1'b1;
    run(c);
    chk(r[0].b.seq, 1'b1);
    chk(r.size(), 3);
    bc(1, seq_pkg::OP_WR, 1'b0, AL);
    chk({r[2].w.base_we, r[2].w.pc_flush}, 2'b10);
    abt(seq_pkg::OP_WR, AL);
    run(c);
    chk(r[2].w.base_we, 1'b0);
    abt(seq_pkg::OP_IN, 32'h0);
    c.base_pc = 1'b1;
    run(c);
    chk(r.size(), 5);
    bc(2, seq_pkg::OP_RD, 1'b0, WB);
    chk(r[2].w.pc_flush, 1'b1);
    bc(3, seq_pkg::OP_RD, 1'b1, WB + 32'h4);
    c.wb = 1'b0;
    run(c);
    chk(r.size(), 3);
    c = '0;
    c.cls = seq_pkg::CL_STM;
    c.nregs = 5'h3;
    run(c);
    chk(r.size(), 5);
    for (int k = 1; k < 4; k++) bc(k, seq_pkg::OP_WR, k > 1, AL + 32'h4 * (k - 1));
    c.cls = seq_pkg::CL_LDM;
    c.wb = 1'b1;
    run(c);
    chk(r.size(), 6);
    for (int k = 1; k < 4; k++) bc(k, seq_pkg::OP_RD, k > 1, AL + 32'h4 * (k - 1));
    bc(4, seq_pkg::OP_IN, 1'bx, PCV + 32'hC);
    chk({r[2].w.rd_we, r[3].w.rd_we, r[4].w.rd_we, r[2].w.base_we}, 4'hF);
    c.pc_in_list = 1'b1;
    abt(seq_pkg::OP_RD, AL + 32'h4);
    run(c);
    chk(r.size(), 6);
    chk({r[2].w.rd_we, r[3].w.rd_we, r[4].w.rd_we}, 3'b100);
    chk(r[4].w.base_restore, 1'b1);
    abt(seq_pkg::OP_IN, 32'h0);
    c.base_pc = 1'b1;
    run(c);
    chk(r[2].w.base_we, 1'b0);
    chk({r.size(), r[4].w.rd_we}, {32'd8, 1'b0});
    bc(5, seq_pkg::OP_RD, 1'b0, AL + 32'h108);
    chk(r[5].w.pc_flush, 1'b1);
    c = '0;
    c.cls = seq_pkg::CL_SWP;
    c.byte_sz = 1'b1;
    run(c);
    chk(r.size(), 5);
    bc(1, seq_pkg::OP_RD, 1'b0, AL);
    bc(2, seq_pkg::OP_WR, 1'b0, AL);
    chk({r[1].b.bypass, r[3].w.rd_we}, 2'b11);
    chk({r[0].b.lock, r[1].b.lock, r[2].b.lock, r[3].b.lock}, 4'b0110);
    for (int k = 0; k < 2; k++) begin
      abt(k ? seq_pkg::OP_WR : seq_pkg::OP_RD, AL);
      run(c);
      chk(r[3].w.rd_we, 1'b0);
    end
    abt(seq_pkg::OP_IN, 32'h0);
    c.base_pc = 1'b1;
    for (int k = 0; k < 2; k++) begin
      c.flags_set = (k == 0);
      c.irq_dis = (k == 1);
      run(c);
      chk({n_ae, hits(VEC)}, {32'd1, 32'd1});
    end
    c.irq_dis = 1'b0;
    c.mode = 2'h1;
    run(c);
    bc(1, seq_pkg::OP_RD, 1'b0, PCV + 32'h9);
    chk(n_ae, 0);
    c = '0;
    c.cls = seq_pkg::CL_EXC;
    run(c);
    chk(r.size(), 4);
    chk({r[0].b.supervisor_mode, r[0].w.r14_we, r[1].w.r14_adj}, 3'b111);
    bc(1, seq_pkg::OP_RD, 1'b0, VEC);
    bc(2, seq_pkg::OP_RD, 1'b1, VEC + 32'h4);
    chk({r[1].b.supervisor_mode, r[2].b.supervisor_mode}, 2'b11);
    c.cls = seq_pkg::CL_CDP;
    cp(1'b1, 4'h0);
    run(c);
    chk({n_cpi, n_ud}, {32'd1, 32'd0});
    chk({r[1].b.op, r[1].b.opcode_fetch_n}, {seq_pkg::OP_IN, 1'b0});
    cp(1'b1, 4'hC);
    run(c);
    chk({n_cpi > 1, n_ud}, {1'b1, 32'd0});
    // An undefined encoding is never claimed, so the lines stay at the pull-up level
    cp(1'b0, 4'h0);
    run(c);
    chk({n_ud, hits(VEC)}, {32'd1, 32'd1});
    conclude();
  end
endmodule
